// [logic/gtm_pkg.sv]
// Summary of operation
// RULE1: Each enabled input pin uses its trigger-type bit to pick level or edge detection.
// RULE2: Trigger-type bit zero selects level detection, one selects edge detection.
// RULE3: Trigger-type and dual-edge registers hold one independent bit per pin, bits 0 to 8.
// RULE4: Software writes zero into bits 9 to 31 of both registers.
// RULE5: Trigger type matters only for pins that are inputs with interrupt enabled.
// RULE6: Dual-edge bit acts only in edge mode and is ignored in level mode.
// RULE7: Dual-edge bit one makes rising and falling edges both raise the interrupt.
// RULE8: Dual-edge bit zero in edge mode lets only the polarity-chosen edge trigger.
// RULE9: Trigger-type register is a 32-bit read/write register reading back as written.
// RULE10: Polarity zero means high level or rising edge, one means low or falling.
// RULE11: A pin is an interrupt source only while its enable bit is one.
// RULE12: A qualifying event is latched per pin until software writes one to clear it.
// RULE13: Both registers reset to zero; edges compare input with its previous sample.
package gtm_pkg;

  localparam int GTM_PINS = 9;
  localparam int GTM_ADDR_W = 8;
  localparam int GTM_DATA_W = 32;
  localparam int GTM_SYNC_STAGES = 3;

  localparam logic [GTM_ADDR_W-1:0] GTM_OFS_PIN_LEVEL = 8'h00;
  localparam logic [GTM_ADDR_W-1:0] GTM_OFS_PIN_INPUT = 8'h08;
  localparam logic [GTM_ADDR_W-1:0] GTM_OFS_SOURCE_ENABLE = 8'h10;
  localparam logic [GTM_ADDR_W-1:0] GTM_OFS_POLARITY = 8'h14;
  localparam logic [GTM_ADDR_W-1:0] GTM_OFS_TRIGGER_TYPE = 8'h18;
  localparam logic [GTM_ADDR_W-1:0] GTM_OFS_DUAL_EDGE = 8'h1C;
  localparam logic [GTM_ADDR_W-1:0] GTM_OFS_LATCH_CLEAR = 8'h20;
  localparam logic [GTM_ADDR_W-1:0] GTM_OFS_IRQ_STATUS = 8'h28;
  localparam logic [GTM_ADDR_W-1:0] GTM_OFS_IRQ_MASK = 8'h2C;

  localparam logic [GTM_PINS-1:0] GTM_RST_PIN_INPUT = 9'h1FF;
  localparam logic [GTM_PINS-1:0] GTM_RST_SOURCE_ENABLE = 9'h000;
  localparam logic [GTM_PINS-1:0] GTM_RST_POLARITY = 9'h000;
  localparam logic [GTM_PINS-1:0] GTM_RST_TRIGGER_TYPE = 9'h000;
  localparam logic [GTM_PINS-1:0] GTM_RST_DUAL_EDGE = 9'h000;
  localparam logic [GTM_PINS-1:0] GTM_RST_IRQ_STATUS = 9'h000;
  localparam logic [GTM_PINS-1:0] GTM_RST_IRQ_MASK = 9'h000;

  localparam logic GTM_TRIGGER_LEVEL = 1'h0;
  localparam logic GTM_TRIGGER_EDGE = 1'h1;
  localparam logic GTM_POLARITY_HIGH_RISE = 1'h0;
  localparam logic GTM_POLARITY_LOW_FALL = 1'h1;

  typedef struct packed {
    logic read;
    logic write;
    logic [GTM_ADDR_W-1:0] address;
    logic [3:0] byteenable;
    logic [GTM_DATA_W-1:0] writedata;
  } gtm_bus_req_type;

  typedef enum logic {
    GTM_BUS_IDLE,
    GTM_BUS_ANSWER
  } gtm_bus_state_type;

endpackage

// [logic/gtm_trigger.sv]
module gtm_trigger import gtm_pkg::*; (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_clk_en,
  input wire gtm_bus_req_type i_bus,
  output logic [GTM_DATA_W-1:0] o_readdata,
  output logic o_waitrequest,
  input wire logic [GTM_PINS-1:0] i_gpio_in,
  output logic o_irq
);

  // Merges the low byte lanes of a write into a pin-wide register image.
  // Bits 9 to 31 are dropped, so reserved bits always read as zero.
  function automatic logic [GTM_PINS-1:0] merge_write(
    input logic [GTM_PINS-1:0] old_value,
    input logic [GTM_DATA_W-1:0] data,
    input logic [3:0] byteenable
  );
    logic [GTM_PINS-1:0] result;
    result = old_value;
    if (byteenable[0]) begin
      result[7:0] = data[7:0];
    end
    if (byteenable[1]) begin
      result[8] = data[8];
    end
    return result;
  endfunction

  // Picks out the write-one-to-clear bits of a write within the live byte lanes.
  function automatic logic [GTM_PINS-1:0] clear_bits(
    input logic [GTM_DATA_W-1:0] data,
    input logic [3:0] byteenable
  );
    logic [GTM_PINS-1:0] result;
    result = '0;
    if (byteenable[0]) begin
      result[7:0] = data[7:0];
    end
    if (byteenable[1]) begin
      result[8] = data[8];
    end
    return result;
  endfunction

  function automatic logic [GTM_DATA_W-1:0] widen(input logic [GTM_PINS-1:0] value);
    return {{(GTM_DATA_W-GTM_PINS){1'h0}}, value};
  endfunction

  gtm_bus_state_type bus_state;
  gtm_bus_state_type next_bus_state;

  logic [GTM_PINS-1:0] pin_sync_a;
  logic [GTM_PINS-1:0] pin_sync_b;
  logic [GTM_PINS-1:0] pin_sync_c;
  logic [GTM_PINS-1:0] pin_level;
  logic [GTM_PINS-1:0] pin_level_prev;

  logic [GTM_PINS-1:0] pin_input;
  logic [GTM_PINS-1:0] irq_source_enable;
  logic [GTM_PINS-1:0] irq_polarity_select;
  logic [GTM_PINS-1:0] irq_trigger_type_select;
  logic [GTM_PINS-1:0] irq_dual_edge_select;
  logic [GTM_PINS-1:0] irq_latch;
  logic [GTM_PINS-1:0] irq_mask;

  logic [GTM_PINS-1:0] pin_armed;
  logic [GTM_PINS-1:0] rise_seen;
  logic [GTM_PINS-1:0] fall_seen;
  logic [GTM_PINS-1:0] level_hit;
  logic [GTM_PINS-1:0] edge_hit;
  logic [GTM_PINS-1:0] pin_event;
  logic [GTM_PINS-1:0] latch_clear;

  logic bus_request;
  logic bus_commit;
  logic write_commit;
  logic [GTM_DATA_W-1:0] next_readdata;

  // Bus handshake: a request is looked at in the idle state and answered
  // one cycle later, so with the clock enable high every access takes exactly two edges.
  assign bus_request = i_bus.read | i_bus.write;
  assign bus_commit = i_clk_en & (bus_state == GTM_BUS_ANSWER);
  assign write_commit = bus_commit & i_bus.write;

  // Waitrequest stays high while the clock enable is low, because the
  // master would otherwise finish an access that the registers never saw.
  assign o_waitrequest = ~bus_commit;

  always_comb begin
    next_bus_state = bus_state;
    unique case (bus_state)
      GTM_BUS_IDLE: begin
        if (bus_request) begin
          next_bus_state = GTM_BUS_ANSWER;
        end
      end
      GTM_BUS_ANSWER: begin
        next_bus_state = GTM_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      bus_state <= GTM_BUS_IDLE;
    end else if (i_clk_en) begin
      bus_state <= next_bus_state;
    end
  end

  // Read data is captured in the idle cycle and stands through the answer.
  always_comb begin
    next_readdata = '0;
    unique case (i_bus.address)
      GTM_OFS_PIN_LEVEL: next_readdata = widen(pin_level);
      GTM_OFS_PIN_INPUT: next_readdata = widen(pin_input);
      GTM_OFS_SOURCE_ENABLE: next_readdata = widen(irq_source_enable);
      GTM_OFS_POLARITY: next_readdata = widen(irq_polarity_select);
      GTM_OFS_TRIGGER_TYPE: next_readdata = widen(irq_trigger_type_select); // see RULE9
      GTM_OFS_DUAL_EDGE: next_readdata = widen(irq_dual_edge_select);
      GTM_OFS_IRQ_STATUS: next_readdata = widen(irq_latch);
      GTM_OFS_IRQ_MASK: next_readdata = widen(irq_mask);
      default: next_readdata = '0;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_readdata <= '0;
    end else if (i_clk_en && bus_state == GTM_BUS_IDLE && i_bus.read) begin
      o_readdata <= next_readdata;
    end
  end

  // Pin inputs are asynchronous; a new level is accepted only once the
  // second and third stages agree, which rejects a single-cycle glitch.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pin_sync_a <= '0;
      pin_sync_b <= '0;
      pin_sync_c <= '0;
    end else if (i_clk_en) begin
      pin_sync_a <= i_gpio_in;
      pin_sync_b <= pin_sync_a;
      pin_sync_c <= pin_sync_b;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pin_level <= '0;
    end else if (i_clk_en) begin
      for (int i = 0; i < GTM_PINS; i++) begin
        if (pin_sync_b[i] == pin_sync_c[i]) begin
          pin_level[i] <= pin_sync_c[i];
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pin_level_prev <= '0;
    end else if (i_clk_en) begin
      pin_level_prev <= pin_level; // see RULE13
    end
  end

  // Configuration registers.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pin_input <= GTM_RST_PIN_INPUT;
    end else if (write_commit && i_bus.address == GTM_OFS_PIN_INPUT) begin
      pin_input <= merge_write(pin_input, i_bus.writedata, i_bus.byteenable);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_source_enable <= GTM_RST_SOURCE_ENABLE;
    end else if (write_commit && i_bus.address == GTM_OFS_SOURCE_ENABLE) begin
      irq_source_enable <= merge_write(irq_source_enable, i_bus.writedata, i_bus.byteenable);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_polarity_select <= GTM_RST_POLARITY;
    end else if (write_commit && i_bus.address == GTM_OFS_POLARITY) begin
      irq_polarity_select <= merge_write(irq_polarity_select, i_bus.writedata,
        i_bus.byteenable);
    end
  end

  // Upper bits are expected to be written as zero; they are not stored.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_trigger_type_select <= GTM_RST_TRIGGER_TYPE; // see RULE13
    end else if (write_commit && i_bus.address == GTM_OFS_TRIGGER_TYPE) begin
      irq_trigger_type_select <= merge_write(irq_trigger_type_select, i_bus.writedata,
        i_bus.byteenable); // see RULE3 see RULE9 see RULE4
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_dual_edge_select <= GTM_RST_DUAL_EDGE; // see RULE13
    end else if (write_commit && i_bus.address == GTM_OFS_DUAL_EDGE) begin
      irq_dual_edge_select <= merge_write(irq_dual_edge_select, i_bus.writedata,
        i_bus.byteenable); // see RULE3 see RULE4
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_mask <= GTM_RST_IRQ_MASK;
    end else if (write_commit && i_bus.address == GTM_OFS_IRQ_MASK) begin
      irq_mask <= merge_write(irq_mask, i_bus.writedata, i_bus.byteenable);
    end
  end

  // Event detection per pin.
  assign pin_armed = pin_input & irq_source_enable; // see RULE5 see RULE11
  assign rise_seen = pin_level & ~pin_level_prev; // see RULE13
  assign fall_seen = ~pin_level & pin_level_prev;

  always_comb begin
    level_hit = '0;
    edge_hit = '0;
    for (int i = 0; i < GTM_PINS; i++) begin
      if (irq_polarity_select[i] == GTM_POLARITY_LOW_FALL) begin
        level_hit[i] = ~pin_level[i]; // see RULE10
      end else begin
        level_hit[i] = pin_level[i];
      end
      if (irq_dual_edge_select[i]) begin
        edge_hit[i] = rise_seen[i] | fall_seen[i]; // see RULE7
      end else if (irq_polarity_select[i] == GTM_POLARITY_LOW_FALL) begin
        edge_hit[i] = fall_seen[i]; // see RULE8 see RULE10
      end else begin
        edge_hit[i] = rise_seen[i]; // see RULE8
      end
    end
  end

  // The dual-edge bit only reaches the event through the edge branch,
  // so in level mode it has no effect at all.
  always_comb begin
    pin_event = '0;
    for (int i = 0; i < GTM_PINS; i++) begin
      if (irq_trigger_type_select[i] == GTM_TRIGGER_EDGE) begin
        pin_event[i] = pin_armed[i] & edge_hit[i]; // see RULE1 see RULE2 see RULE6
      end else begin
        pin_event[i] = pin_armed[i] & level_hit[i]; // see RULE1 see RULE2
      end
    end
  end

  // Latch clear comes from either the dedicated clear register or a
  // write-one-to-clear on the status register; both clear the same latch.
  always_comb begin
    latch_clear = '0;
    if (write_commit && (i_bus.address == GTM_OFS_LATCH_CLEAR ||
        i_bus.address == GTM_OFS_IRQ_STATUS)) begin
      latch_clear = clear_bits(i_bus.writedata, i_bus.byteenable);
    end
  end

  // A new event wins over a clear in the same cycle. A persisting active
  // level therefore keeps the latch set through the clear, with no cycle at zero.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_latch <= GTM_RST_IRQ_STATUS;
    end else if (i_clk_en) begin
      irq_latch <= (irq_latch & ~latch_clear) | pin_event; // see RULE12
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_irq <= 1'h0;
    end else if (i_clk_en) begin
      o_irq <= |(((irq_latch & ~latch_clear) | pin_event) & irq_mask);
    end
  end

endmodule

// [dv/gtm_pin_source.sv]
module gtm_pin_source import gtm_pkg::*; (
  input wire logic [GTM_PINS-1:0] i_level,
  output wire logic [GTM_PINS-1:0] o_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pins move off the clock grid, so the input synchronizer sees a truly asynchronous change.
  assign #30 o_pin = i_level;
endmodule

// [dv/gtm_trigger_properties.sv]
module gtm_trigger_properties import gtm_pkg::*; (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_clk_en,
  input wire gtm_bus_req_type i_bus,
  input wire logic [GTM_DATA_W-1:0] o_readdata,
  input wire logic o_waitrequest,
  input wire logic [GTM_PINS-1:0] i_gpio_in,
  input wire logic o_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  logic req;
  assign req = i_bus.read || i_bus.write;
  answer_once_a: assert property (
    req && o_waitrequest && i_clk_en ##1 i_clk_en |-> !o_waitrequest)
    else $error("request not answered after one cycle");
  answer_short_a: assert property (!o_waitrequest |=> o_waitrequest)
    else $error("answer lasted more than one cycle");
  freeze_wait_a: assert property (!i_clk_en |-> o_waitrequest)
    else $error("answer given while clock enable low");
  idle_wait_a: assert property (!req |-> o_waitrequest)
    else $error("answer given without a request");
  freeze_state_a: assert property (
    !i_clk_en |=> $stable(o_irq) && $stable(o_readdata))
    else $error("state moved while clock enable low");
  upper_zero_a: assert property (
    !o_waitrequest && i_bus.read |-> o_readdata[31:9] == 23'h0)
    else $error("unused upper bits read nonzero");
  clear_reads_a: assert property (
    !o_waitrequest && i_bus.read && i_bus.address == GTM_OFS_LATCH_CLEAR |-> o_readdata == 32'h0)
    else $error("latch clear register read nonzero");
  irq_fall_a: assert property (
    $fell(o_irq) |-> $past(i_bus.write) || $past(i_bus.write, 2))
    else $error("interrupt dropped without a software write");
endmodule

bind gtm_trigger gtm_trigger_properties u_gtm_trigger_properties (.i_ref_clk(i_ref_clk),
  .i_resetn(i_resetn), .i_clk_en(i_clk_en), .i_bus(i_bus), .o_readdata(o_readdata),
  .o_waitrequest(o_waitrequest), .i_gpio_in(i_gpio_in), .o_irq(o_irq));

// [dv/gtm_trigger_tb.sv]
module gtm_trigger_tb import gtm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_ref_clk = 1'h0;
  logic i_resetn = 1'h0;
  logic i_clk_en = 1'h1;
  gtm_bus_req_type i_bus = '0;
  logic [GTM_DATA_W-1:0] o_readdata;
  logic o_waitrequest;
  logic o_irq;
  logic [GTM_PINS-1:0] pin_level = 9'h000;
  wire logic [GTM_PINS-1:0] gpio;
  int miscompares = 0;
  int total_checks = 0;

  always #50 i_ref_clk = ~i_ref_clk;

  gtm_trigger u_gtm_trigger (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_clk_en(i_clk_en),
    .i_bus(i_bus), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_gpio_in(gpio),
    .o_irq(o_irq));
  gtm_pin_source u_gtm_pin_source (.i_level(pin_level), .o_pin(gpio));

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Values are read straight after the edge, so they are the ones the edge sampled.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r);
    int n;
    n = 0;
    i_bus <= '{read: !w, write: w, address: a, byteenable: 4'hF, writedata: d};
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (o_waitrequest !== 1'h0 && n < 50);
    if (n >= 50) begin
      miscompares++;
      end_sim();
    end
    r = o_readdata;
    i_bus <= '0;
    @(posedge i_ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'h1, a, d, r);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'h0, a, 32'h0, r);
    chk(nm, e, r);
  endtask

  task automatic s_regs;
    rdc("trig_reset", GTM_OFS_TRIGGER_TYPE, 32'h0);
    rdc("dual_reset", GTM_OFS_DUAL_EDGE, 32'h0);
    wr(GTM_OFS_TRIGGER_TYPE, 32'h00000155);
    wr(GTM_OFS_DUAL_EDGE, 32'h000000AA);
    rdc("trig_rw", GTM_OFS_TRIGGER_TYPE, 32'h00000155);
    rdc("dual_rw", GTM_OFS_DUAL_EDGE, 32'h000000AA);
    rdc("unmapped", 8'h04, 32'h0);
    rdc("clear_reads", GTM_OFS_LATCH_CLEAR, 32'h0);
  endtask

  task automatic s_freeze;
    logic [31:0] r;
    i_clk_en <= 1'h0;
    fork
      bus(1'h0, GTM_OFS_TRIGGER_TYPE, 32'h0, r);
      begin
        repeat (4) @(posedge i_ref_clk);
        chk("frozen_wait", 32'h1, 32'(o_waitrequest));
        i_clk_en <= 1'h1;
      end
    join
    chk("frozen_read", 32'h00000155, r);
  endtask

  // One pin k is armed alone; the latch is cleared once the start level has settled.
  task automatic trial(input int k, input logic en, inp, m, t, d, p, s, e, ev, aft);
    logic [8:0] b;
    logic [31:0] r;
    b = 9'h001 << k;
    pin_level[k] <= s;
    wr(GTM_OFS_PIN_INPUT, 32'(inp ? 9'h1FF : ~b));
    wr(GTM_OFS_SOURCE_ENABLE, 32'(b & {9{en}}));
    wr(GTM_OFS_POLARITY, 32'(b & {9{p}}));
    wr(GTM_OFS_TRIGGER_TYPE, 32'(b & {9{t}}));
    wr(GTM_OFS_DUAL_EDGE, 32'(b & {9{d}}));
    wr(GTM_OFS_IRQ_MASK, 32'(b & {9{m}}));
    repeat (8) @(posedge i_ref_clk);
    wr(GTM_OFS_LATCH_CLEAR, 32'h000001FF);
    pin_level[k] <= e;
    repeat (12) @(posedge i_ref_clk);
    chk("irq_event", 32'(ev & m), 32'(o_irq));
    bus(1'h0, GTM_OFS_IRQ_STATUS, 32'h0, r);
    chk("latched", 32'(b & {9{ev}}), r);
    wr(GTM_OFS_LATCH_CLEAR, 32'(b));
    repeat (8) @(posedge i_ref_clk);
    chk("irq_after_clear", 32'(aft & m), 32'(o_irq));
  endtask

  // A reset in mid-run must return every pin to level detection with a single edge.
  task automatic s_reset;
    wr(GTM_OFS_TRIGGER_TYPE, 32'h000001FF);
    wr(GTM_OFS_DUAL_EDGE, 32'h000001FF);
    rdc("dual_all", GTM_OFS_DUAL_EDGE, 32'h000001FF);
    i_resetn <= 1'h0;
    repeat (2) @(posedge i_ref_clk);
    i_resetn <= 1'h1;
    @(posedge i_ref_clk);
    rdc("trig_rerun", GTM_OFS_TRIGGER_TYPE, 32'h0);
    rdc("dual_rerun", GTM_OFS_DUAL_EDGE, 32'h0);
    chk("irq_rerun", 32'h0, 32'(o_irq));
  endtask

  initial begin
    repeat (2) @(posedge i_ref_clk);
    i_resetn <= 1'h1;
    @(posedge i_ref_clk);
    s_regs();
    s_freeze();
    trial(0, 1, 1, 1, 0, 0, 0, 0, 1, 1, 1);
    trial(8, 1, 1, 1, 0, 0, 1, 1, 0, 1, 1);
    trial(0, 1, 1, 1, 0, 1, 0, 0, 1, 1, 1);
    trial(0, 1, 1, 1, 1, 0, 0, 0, 1, 1, 0);
    trial(8, 1, 1, 1, 1, 0, 0, 1, 0, 0, 0);
    trial(0, 1, 1, 1, 1, 0, 1, 1, 0, 1, 0);
    trial(0, 1, 1, 1, 1, 0, 1, 0, 1, 0, 0);
    trial(8, 1, 1, 1, 1, 1, 0, 1, 0, 1, 0);
    trial(0, 1, 1, 1, 1, 1, 1, 0, 1, 1, 0);
    trial(0, 0, 1, 1, 0, 0, 0, 0, 1, 0, 0);
    trial(0, 1, 0, 1, 1, 0, 0, 0, 1, 0, 0);
    trial(8, 1, 1, 0, 1, 0, 0, 0, 1, 1, 0);
    s_reset();
    end_sim();
  end
endmodule
